// [hw/ees_slave.sv]
`timescale 1ns/1ps
// What this block does
// - Start is data falling while clock stays high.
// - Start is always watched, except while an internal write runs.
// - Stop is data rising while clock high; it ends the transfer.
// - Unacknowledged read byte followed by stop returns the slave to standby.
// - Data is sampled on each rising clock; master changes it only while low.
// - After eight bits the receiver pulls data low in the ninth pulse.
// - Select byte arrives MSB first; type 1010 reaches the main array.
// - Select bits b3..b1 must equal the three strap inputs.
// - Select bit 0 gives direction: one read, zero write.
// - Matching select is acknowledged; mismatch releases bus and goes standby.
// - After write select, take and acknowledge two address bytes, then data.
// - Stop in the tenth slot after data acknowledge starts the write.
// - Stop anywhere else ends the transfer with no write.
// - After a completed write the counter points past the written byte.
// - During the write the output stays off and the bus is ignored.
// - Protect input high blocks the write and data acknowledge.
// - Single byte write stores the byte unless protected.
// - Reset releases into standby; nothing is accepted during reset.
// - Stop with no write running puts the slave in standby.
// - Under protection, select and address bytes are still acknowledged.
// - Protect input low allows writes.
// - Array holds 4096 bytes addressed by the low twelve address bits.
module ees_slave
  import ees_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES,
  parameter int unsigned FILT = FILT_LEN
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [2:0] chip_select_straps_i,
  input wire logic write_protect_in_i,
  output logic busy_o,
  output logic [ARRAY_AW-1:0] addr_counter_o,
  input wire logic [ARRAY_AW-1:0] peek_addr_i,
  output logic [7:0] peek_data_o
);

  localparam int unsigned TW = $clog2(PROG_CYC + 1);

  function automatic logic rose(input logic prev, input logic cur);
    rose = cur & ~prev;
  endfunction

  // ****************************************************************
  // Link domain reset and pin synchronisers
  // ****************************************************************
  logic lk_rst_a_reg;
  logic lk_rst_n_reg;
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic done_meta_reg;
  logic done_sync_reg;
  logic done_prev_reg;
  logic done_tgl_reg;

  // Reset leaves the link domain in step with its own clock
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lk_rst_a_reg <= 1'b0;
      lk_rst_n_reg <= 1'b0;
    end else begin
      lk_rst_a_reg <= 1'b1;
      lk_rst_n_reg <= lk_rst_a_reg;
    end
  end

  always_ff @(posedge link_clk_i or negedge lk_rst_n_reg) begin
    if (!lk_rst_n_reg) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      strap_meta_reg <= chip_select_straps_i;
      strap_sync_reg <= strap_meta_reg;
      wp_meta_reg <= write_protect_in_i;
      wp_sync_reg <= wp_meta_reg;
      done_meta_reg <= done_tgl_reg;
      done_sync_reg <= done_meta_reg;
      done_prev_reg <= done_sync_reg;
    end
  end

  // ****************************************************************
  // Glitch filter and condition detect
  // ****************************************************************
  logic [FILT-1:0] scl_hist_reg;
  logic [FILT-1:0] sda_hist_reg;
  logic scl_f_reg;
  logic sda_f_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // A level is taken only after FILT equal samples, so short spikes are lost
  always_ff @(posedge link_clk_i or negedge lk_rst_n_reg) begin
    if (!lk_rst_n_reg) begin
      scl_hist_reg <= '1;
      sda_hist_reg <= '1;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_hist_reg <= {scl_hist_reg[FILT-2:0], scl_sync_reg};
      sda_hist_reg <= {sda_hist_reg[FILT-2:0], sda_sync_reg};
      if (&scl_hist_reg) begin
        scl_f_reg <= 1'b1;
      end else if (~|scl_hist_reg) begin
        scl_f_reg <= 1'b0;
      end
      if (&sda_hist_reg) begin
        sda_f_reg <= 1'b1;
      end else if (~|sda_hist_reg) begin
        sda_f_reg <= 1'b0;
      end
      scl_prev_reg <= scl_f_reg;
      sda_prev_reg <= sda_f_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic scl_high;

  assign scl_rise = rose(scl_prev_reg, scl_f_reg);
  assign scl_fall = rose(scl_f_reg, scl_prev_reg);
  assign scl_high = scl_f_reg & scl_prev_reg;
  assign start_det = scl_high & rose(sda_f_reg, sda_prev_reg);
  assign stop_det = scl_high & rose(sda_prev_reg, sda_f_reg);

  // ****************************************************************
  // Protocol sequencer
  // ****************************************************************
  ees_phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_ok_reg;
  logic rw_reg;
  logic wr_ok_reg;
  logic [BUS_AW-1:0] addr_reg;
  logic [7:0] data_reg;
  logic oe_n_reg;
  logic req_tgl_reg;
  logic pend_reg;
  logic [7:0] byte_in;
  logic sel_match;
  logic in_byte;

  assign byte_in = {shift_reg[6:0], sda_f_reg};
  assign sel_match = (byte_in[TYPE_MSB:TYPE_LSB] == TYPE_MAIN_ARRAY) &&
                     (byte_in[STRAP_MSB:STRAP_LSB] == strap_sync_reg);
  assign in_byte = (phase_reg == PH_SEL) || (phase_reg == PH_AHI) ||
                   (phase_reg == PH_ALO) || (phase_reg == PH_DATA);

  // Pending covers the gap before the core domain reports completion
  always_ff @(posedge link_clk_i or negedge lk_rst_n_reg) begin
    if (!lk_rst_n_reg) begin
      pend_reg <= 1'b0;
    end else if (stop_det && phase_reg == PH_SLOT10 && wr_ok_reg && !pend_reg) begin
      pend_reg <= 1'b1;
    end else if (done_sync_reg != done_prev_reg) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or negedge lk_rst_n_reg) begin
    if (!lk_rst_n_reg) begin
      req_tgl_reg <= 1'b0;
    end else if (stop_det && phase_reg == PH_SLOT10 && wr_ok_reg && !pend_reg) begin
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  always_ff @(posedge link_clk_i or negedge lk_rst_n_reg) begin
    if (!lk_rst_n_reg) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= BYTE_RST;
      ack_ok_reg <= 1'b0;
      rw_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
      addr_reg <= ADDR_RST;
      data_reg <= BYTE_RST;
      oe_n_reg <= 1'b1;
    end else if (pend_reg) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      oe_n_reg <= 1'b1;
    end else if (start_det) begin
      phase_reg <= PH_SEL;
      bit_cnt_reg <= 4'h0;
      wr_ok_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (stop_det) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      oe_n_reg <= 1'b1;
    end else if (scl_rise) begin
      unique case (phase_reg)
        PH_SEL, PH_AHI, PH_ALO, PH_DATA: begin
          if (bit_cnt_reg < BIT_ACK_SLOT) begin
            shift_reg <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else begin
            bit_cnt_reg <= BIT_ACK_DONE;
          end
          if (bit_cnt_reg == BIT_LAST_DATA) begin
            unique case (phase_reg)
              PH_SEL: begin
                ack_ok_reg <= sel_match;
                rw_reg <= byte_in[RW_BIT];
                if (!sel_match) begin
                  phase_reg <= PH_IDLE;
                end
              end
              PH_AHI: begin
                addr_reg[15:8] <= byte_in;
                ack_ok_reg <= 1'b1;
              end
              PH_ALO: begin
                addr_reg[7:0] <= byte_in;
                ack_ok_reg <= 1'b1;
              end
              default: begin
                data_reg <= byte_in;
                ack_ok_reg <= ~wp_sync_reg;
                wr_ok_reg <= ~wp_sync_reg;
              end
            endcase
          end
        end
        // The tenth clock rises ahead of a stop, so only its fall may cancel
        PH_IDLE, PH_HOLD, PH_SLOT10: begin
          bit_cnt_reg <= 4'h0;
        end
        default: begin
          phase_reg <= PH_IDLE;
        end
      endcase
    end else if (scl_fall && phase_reg == PH_SLOT10) begin
      // Extra data bytes are not supported; the write is dropped
      phase_reg <= PH_HOLD;
      wr_ok_reg <= 1'b0;
    end else if (scl_fall && in_byte) begin
      if (bit_cnt_reg == BIT_ACK_SLOT) begin
        oe_n_reg <= ~ack_ok_reg;
      end else if (bit_cnt_reg == BIT_ACK_DONE) begin
        oe_n_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
        unique case (phase_reg)
          PH_SEL: phase_reg <= rw_reg ? PH_HOLD : PH_AHI;
          PH_AHI: phase_reg <= PH_ALO;
          PH_ALO: phase_reg <= PH_DATA;
          default: phase_reg <= PH_SLOT10;
        endcase
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge lk_rst_n_reg) begin
    if (!lk_rst_n_reg) begin
      sda_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      sda_oe_n_o <= oe_n_reg;
      sda_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Core domain: request crossing
  // ****************************************************************
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_prev_reg;
  logic req_evt;
  ees_wr_req_t req_hold_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_prev_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
      req_prev_reg <= req_sync_reg;
    end
  end

  assign req_evt = req_sync_reg ^ req_prev_reg;

  // Link payload is frozen while pending, so it is stable when sampled here
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_hold_reg <= '0;
    end else if (req_evt) begin
      req_hold_reg.addr <= addr_reg[ARRAY_AW-1:0];
      req_hold_reg.data <= data_reg;
    end
  end

  // ****************************************************************
  // Core domain: program timer and array
  // ****************************************************************
  logic [TW-1:0] timer_reg;
  logic [7:0] mem [ARRAY_WORDS];
  logic prog_end;

  assign prog_end = busy_o && (timer_reg == TW'(PROG_CYC - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      timer_reg <= '0;
    end else if (req_evt) begin
      busy_o <= 1'b1;
      timer_reg <= '0;
    end else if (prog_end) begin
      busy_o <= 1'b0;
    end else if (busy_o) begin
      timer_reg <= timer_reg + TW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (prog_end) begin
      mem[req_hold_reg.addr] <= req_hold_reg.data;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_tgl_reg <= 1'b0;
      addr_counter_o <= CNT_RST;
    end else if (prog_end) begin
      done_tgl_reg <= ~done_tgl_reg;
      addr_counter_o <= req_hold_reg.addr + ARRAY_AW'(1);
    end
  end

  // Observation port; contents are undefined until written
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      peek_data_o <= BYTE_RST;
    end else begin
      peek_data_o <= mem[peek_addr_i];
    end
  end

endmodule // ees_slave

// [pkg/ees_pkg.sv]
package ees_pkg;

  // ****************************************************************
  // Bus framing
  // ****************************************************************
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
  localparam logic [3:0] TYPE_MAIN_ARRAY = 4'b1010;
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned STRAP_MSB = 3;
  localparam int unsigned STRAP_LSB = 1;
  localparam int unsigned RW_BIT = 0;

  // ****************************************************************
  // Array shape
  // ****************************************************************
  localparam int unsigned ARRAY_WORDS = 4096;
  localparam int unsigned ARRAY_AW = 12;
  localparam int unsigned BUS_AW = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PROG_TIME_NS = 100000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FILT_LEN = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [BUS_AW-1:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [ARRAY_AW-1:0] CNT_RST = 12'h000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SEL = 3'b001,
    PH_AHI = 3'b010,
    PH_ALO = 3'b011,
    PH_DATA = 3'b100,
    PH_SLOT10 = 3'b101,
    PH_HOLD = 3'b110
  } ees_phase_t;

  typedef struct packed {
    logic [ARRAY_AW-1:0] addr;
    logic [7:0] data;
  } ees_wr_req_t;

endpackage

// [verification/ees_bus_master.sv]
`timescale 1ns/1ps
// **********
// Bus master model
// **********
module ees_bus_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  localparam int HALF = 300;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Clock stands high between frames
  task automatic start();
    #HALF sda_low_o = 1'b0;
    #HALF scl_o = 1'b1;
    #HALF sda_low_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
  task automatic stop();
    #HALF sda_low_o = 1'b1;
    #HALF scl_o = 1'b1;
    #HALF sda_low_o = 1'b0;
  endtask
  // Data moves halfway through the low phase, after the slave has let go of its acknowledge
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      #HALF sda_low_o = !b[i];
      #HALF scl_o = 1'b1;
      #HALF scl_o = 1'b0;
    end
    if (n == 8) begin
      #HALF sda_low_o = 1'b0;
      #HALF scl_o = 1'b1;
      #(HALF / 2) ack = !sda_i;
      #(HALF / 2) scl_o = 1'b0;
    end
  endtask
endmodule // ees_bus_master

// [verification/ees_slave_chk.sv]
`timescale 1ns/1ps
module ees_slave_chk
  import ees_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [2:0] chip_select_straps_i,
  input wire logic write_protect_in_i,
  input wire logic busy_o,
  input wire logic [ARRAY_AW-1:0] addr_counter_o,
  input wire logic [ARRAY_AW-1:0] peek_addr_i,
  input wire logic [7:0] peek_data_o
);
  // **********
  // Core side
  // **********
  int unsigned busy_cnt_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) busy_cnt_reg <= 0;
    else busy_cnt_reg <= busy_o ? busy_cnt_reg + 1 : 0;
  end
  busy_len_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(busy_o) |-> busy_cnt_reg == PROG_CYC) else $error("write time wrong");
  busy_max_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    busy_o |-> busy_cnt_reg < PROG_CYC) else $error("write time too long");
  busy_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    busy_o |-> sda_oe_n_o) else $error("ack during write");
  count_move_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(addr_counter_o) |-> $fell(busy_o)) else $error("counter moved off write end");
  // Store lands at the write end, so either of the last two cycles may show it
  peek_src_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(peek_data_o) |-> $past(peek_addr_i) != $past(peek_addr_i, 2) || $past(busy_o)
      || $past(busy_o, 2) || !$past(nrst_i, 2)) else $error("array data changed unasked");
  // **********
  // Link side, then covers for both clocks
  // **********
  ack_len_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8] ##[1:40] sda_oe_n_o) else $error("ack length wrong");
  ack_edge_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    $changed(sda_oe_n_o) |-> !scl_i) else $error("ack moved with clock high");
  drive_low_a: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
    !sda_oe_n_o |-> !sda_o) else $error("data driven high");
  write_c: cover property (@(posedge clk_i) $rose(busy_o));
  ack_c: cover property (@(posedge link_clk_i) $fell(sda_oe_n_o));
  count_c: cover property (@(posedge clk_i) $changed(addr_counter_o));
endmodule // ees_slave_chk
bind ees_slave ees_slave_chk #(.PROG_CYC(PROG_CYC)) i_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .chip_select_straps_i(chip_select_straps_i),
  .write_protect_in_i(write_protect_in_i), .busy_o(busy_o), .addr_counter_o(addr_counter_o),
  .peek_addr_i(peek_addr_i), .peek_data_o(peek_data_o));

// [verification/ees_slave_tb.sv]
`timescale 1ns/1ps
module ees_slave_tb
  import ees_pkg::*;
();
  // **********
  // Harness
  // **********
  localparam int unsigned PROG = 2000;
  logic clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] straps = 3'h0;
  logic [ARRAY_AW-1:0] pa = 12'h000;
  logic [ARRAY_AW-1:0] ecnt = 12'h000;
  logic [ARRAY_AW-1:0] cnt;
  logic [7:0] pd;
  logic [7:0] mem [ARRAY_WORDS];
  logic oe_n, sda_d, busy, scl, m_low, sda;
  int err_total = 0;
  int compares = 0;
  always #2.5 clk_i = ~clk_i;
  initial begin
    #3.1;
    forever #15 link_clk = ~link_clk;
  end
  // Pull-up resolves the open-drain data line
  assign sda = !(m_low || (!oe_n && !sda_d));
  ees_bus_master i_bus (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  ees_slave #(.PROG_CYC(PROG), .FILT(FILT_LEN)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_d),
    .sda_oe_n_o(oe_n), .chip_select_straps_i(straps), .write_protect_in_i(wp), .busy_o(busy),
    .addr_counter_o(cnt), .peek_addr_i(pa), .peek_data_o(pd));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hold covers several link clock edges so both domains clear
  task automatic reset_dut();
    @(negedge clk_i) nrst = 1'b0;
    repeat (20) @(negedge clk_i);
    chk("reset oe", oe_n, 1'b1);
    chk("reset busy", busy, 1'b0);
    chk("reset count", cnt, 12'h000);
    nrst = 1'b1;
    ecnt = 12'h000;
  endtask
  task automatic wait_busy(input logic go);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk("busy", busy, go);
    if (busy !== go) wrap_up();
    n = 0;
    while (busy === 1'b1 && n < PROG + 50) begin
      @(negedge clk_i);
      n++;
    end
    if (go) chk("write time", 16'(n), 16'(PROG));
    if (busy === 1'b1) wrap_up();
  endtask
  task automatic sel_try(input logic [7:0] s, input logic exp);
    logic k;
    i_bus.start();
    i_bus.send(s, 8, k);
    chk("select ack", k, exp);
    i_bus.stop();
  endtask
  // cut is the number of data bits before the stop; above eight, bits follow the acknowledge
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int cut, input logic poll);
    logic k, k2, go;
    i_bus.start();
    i_bus.send({TYPE_MAIN_ARRAY, straps, 1'b0}, 8, k);
    chk("sel ack", k, 1'b1);
    i_bus.send(a[15:8], 8, k);
    chk("addr hi ack", k, 1'b1);
    i_bus.send(a[7:0], 8, k);
    chk("addr lo ack", k, 1'b1);
    if (cut != 0) i_bus.send(d, (cut > 8) ? 8 : cut, k);
    if (cut >= 8) chk("data ack", k, !wp);
    // A bit clocked past the data acknowledge cancels the write
    if (cut > 8) i_bus.send(d, cut - 8, k2);
    i_bus.stop();
    go = (cut == 8) && !wp;
    fork
      wait_busy(go);
      if (poll) begin
        i_bus.start();
        i_bus.send({TYPE_MAIN_ARRAY, straps, 1'b0}, 8, k2);
        chk("busy ack", k2, 1'b0);
        i_bus.stop();
      end
    join
    if (go) begin
      mem[a[11:0]] = d;
      ecnt = a[11:0] + 12'h001;
    end
    chk("counter", cnt, ecnt);
    @(negedge clk_i) pa = a[11:0];
    @(negedge clk_i);
    chk("array", pd, mem[a[11:0]]);
  endtask
  // **********
  // Scenarios
  // **********
  initial begin
    logic [15:0] a0;
    logic [7:0] d0;
    void'($urandom(32'h1bbb_900f));
    reset_dut();
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i) straps = 3'($urandom);
      a0 = 16'($urandom);
      d0 = 8'($urandom);
      wr(a0, d0, 8, i == 0);
    end
    wp = 1'b1;
    wr(a0, ~d0, 8, 1'b0);
    wp = 1'b0;
    wr(a0, ~d0, 0, 1'b0);
    wr(a0, ~d0, 3, 1'b0);
    wr(a0, ~d0, 9, 1'b0);
    sel_try({4'b1011, straps, 1'b0}, 1'b0);
    sel_try({TYPE_MAIN_ARRAY, ~straps, 1'b0}, 1'b0);
    sel_try({TYPE_MAIN_ARRAY, straps, 1'b1}, 1'b1);
    wr(16'hffff, d0, 8, 1'b0);
    reset_dut();
    wr(16'($urandom), 8'($urandom), 8, 1'b0);
    wrap_up();
  end
endmodule // ees_slave_tb
